// *** core/spm_pkg.sv ***
// types shared by the serial port design
package spm_pkg;
   typedef enum logic {spm_idle, spm_shift} spm_state_t;
   typedef logic [7:0] spm_byte_t;
endpackage : spm_pkg

// *** core/spm_regs.svh ***
// register indices, field positions, reset values and divider counts of the serial port
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

// register indices; byte address is four times the index
`define SPM_IDX_MAIN_CONTROL 10'h000
`define SPM_IDX_BUF_MODE 10'h001
`define SPM_IDX_IRQ_ENABLE 10'h002
`define SPM_IDX_IRQ_FLAG 10'h003
`define SPM_IDX_DATA 10'h004

`define SPM_MAIN_CONTROL_RST 8'h00
`define SPM_BUF_MODE_RST 8'h00
`define SPM_IRQ_ENABLE_RST 8'h00

// main_control fields
`define SPM_MC_ENABLE 0
`define SPM_MC_DIV_LO 1
`define SPM_MC_DIV_HI 2
`define SPM_MC_CLOCK_DOUBLE 4
`define SPM_MC_MASTER 5
`define SPM_MC_ORDER 6

// buffer_and_mode_control fields
`define SPM_BM_MODE_LO 0
`define SPM_BM_MODE_HI 1
`define SPM_BM_SSD 2
`define SPM_BM_WFR 6
`define SPM_BM_BUFFERED_OPERATION_ON 7

// irq_enable_reg fields
`define SPM_IE_LEGACY 0
`define SPM_IE_SELECT_TRIGGER_IRQ_EN 4
`define SPM_IE_TX_EMPTY_IRQ_EN 5
`define SPM_IE_TRANSFER_DONE_IRQ_EN 6
`define SPM_IE_RECEIVE_DONE_IRQ_EN 7

// irq_flag_reg fields, normal and buffered views
`define SPM_IF_XFER 7
`define SPM_IF_WRITE_COLLISION_FLAG 6
`define SPM_BF_RXC 7
`define SPM_BF_TXC 6
`define SPM_BF_DRE 5
`define SPM_BF_SELECT_TRIGGER_FLAG 4
`define SPM_BF_OVF 0

// half periods of the master clock in mclk cycles for each divider setting
`define SPM_HALF_DIVIDE_BY_FOUR 7'd2
`define SPM_HALF_DIVIDE_BY_SIXTEEN 7'd8
`define SPM_HALF_DIVIDE_BY_SIXTYFOUR 7'd32
`define SPM_HALF_DIVIDE_BY_128_SEL 7'd64

// pin synchroniser reset levels: {ss_n, sck, mosi, miso}
`define SPM_PIN_RST 4'h8

`endif

// *** core/spm_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module spm_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic mclk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic [WIDTH-1:0] async_in, // raw pin levels
   output logic [WIDTH-1:0] filt_out // filtered levels
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               s1[g] <= RST_VAL[g];
               s2[g] <= RST_VAL[g];
               s3[g] <= RST_VAL[g];
               filt_out[g] <= RST_VAL[g];
            end else begin
               s1[g] <= async_in[g];
               s2[g] <= s1[g];
               s3[g] <= s2[g];
               // a change only counts once two settled stages agree
               if (s2[g] == s3[g]) begin
                  filt_out[g] <= s3[g];
               end
            end
         end
      end
   endgenerate
endmodule : spm_sync

// *** core/spm_top.sv ***
// serial peripheral controller, master or slave, with apb registers
// Function
// RULE_01: shift out and sample on opposite edges
// RULE_02: master clock offered as level event
// RULE_03: generates events only, has no inputs
// RULE_04: one interrupt line serves every source
// RULE_05: request holds while enabled flag set
// RULE_06: bit order zero msb first, one lsb
// RULE_07: role bit zero slave, one master
// RULE_08: low select in master drops to slave
// RULE_09: select disable bit blocks that takeover
// RULE_10: clock double halves the master period
// RULE_11: divider selects four, sixteen, 64, 128
// RULE_12: divider settings ignored in slave role
// RULE_13: works only while enable bit set
// RULE_14: buffered mode: two rx, one tx stage
// RULE_15: wait bit zero: first byte is dummy
// RULE_16: wait bit one: first write loads directly
// RULE_17: mode picks sampling and setup edges
// RULE_18: clock idles at leading edge start level
// RULE_19: normal write while busy sets collision
// RULE_20: transfer flag sets per byte, clears
// RULE_21: select high resets slave bit state
// RULE_22: far master holds select, matches mode
// RULE_23: eight clock cycles per byte, idle after
`timescale 1ns/1ps
`include "spm_regs.svh"
module spm_top (
   input wire logic mclk, // system clock, 200 MHz
   input wire logic resetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction, high for write
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic irq_ack, // pulse: interrupt vector executed
   output logic irq, // interrupt request
   output logic sck_event, // master clock level event
   input wire logic sck_in, // clock pin input
   output logic sck_out, // clock pin output
   output logic sck_oe_n, // clock pin enable, low drives
   input wire logic mosi_in, // mosi pin input
   output logic mosi_out, // mosi pin output
   output logic mosi_oe_n, // mosi pin enable, low drives
   input wire logic miso_in, // miso pin input
   output logic miso_out, // miso pin output
   output logic miso_oe_n, // miso pin enable, low drives
   input wire logic ss_n_in // slave select pin, low selects
);
   logic [7:0] main_control;
   logic [7:0] buffer_and_mode_control;
   logic [7:0] irq_enable_reg;
   spm_pkg::spm_byte_t shreg;
   spm_pkg::spm_byte_t txbuf;
   spm_pkg::spm_byte_t rx_buf;
   spm_pkg::spm_byte_t rx_hold;
   spm_pkg::spm_state_t st;
   logic [3:0] pin_f;
   logic [6:0] div_cnt;
   logic [3:0] edge_cnt;
   logic [2:0] nbits;
   logic sck_q;
   logic data_out;
   logic pending_sh;
   logic tx_full;
   logic rx_valid;
   logic hold_valid;
   logic if_flag;
   logic write_collision_flag_flag;
   logic txc_flag;
   logic select_trigger_flag_flag;
   logic ovf_flag;
   logic arm_if;
   logic arm_write_collision_flag;

   spm_sync #(
      .WIDTH(4),
      .RST_VAL(`SPM_PIN_RST)
   ) u_sync (
      .mclk(mclk),
      .resetn(resetn),
      .async_in({ss_n_in, sck_in, mosi_in, miso_in}),
      .filt_out(pin_f)
   );

   wire ss_f = pin_f[3];
   wire sck_f = pin_f[2];
   wire mosi_f = pin_f[1];
   wire miso_f = pin_f[0];

   wire en = main_control[`SPM_MC_ENABLE];
   wire master = main_control[`SPM_MC_MASTER];
   wire clock_double = main_control[`SPM_MC_CLOCK_DOUBLE];
   wire bit_order = main_control[`SPM_MC_ORDER];
   wire [1:0] clock_divider_sel = main_control[`SPM_MC_DIV_HI:`SPM_MC_DIV_LO];
   wire [1:0] mode = buffer_and_mode_control[`SPM_BM_MODE_HI:`SPM_BM_MODE_LO];
   wire cpol = mode[1];
   wire cpha = mode[0];
   wire select_line_disable = buffer_and_mode_control[`SPM_BM_SSD];
   wire wait_for_receive = buffer_and_mode_control[`SPM_BM_WFR];
   wire buffered_operation_on = buffer_and_mode_control[`SPM_BM_BUFFERED_OPERATION_ON];

   // apb decode
   wire [9:0] idx = paddr[11:2];
   wire acc = psel && penable && pready;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire mapped = (paddr[1:0] == 2'h0) && (idx <= `SPM_IDX_DATA);
   wire wr_data = wr && mapped && idx == `SPM_IDX_DATA;
   wire rd_data = rd && mapped && idx == `SPM_IDX_DATA;
   wire wr_flags = wr && mapped && idx == `SPM_IDX_IRQ_FLAG;
   wire rd_flags = rd && mapped && idx == `SPM_IDX_IRQ_FLAG;
   wire wr_main = wr && mapped && idx == `SPM_IDX_MAIN_CONTROL;
   wire data_touch = (wr_data || rd_data) && !buffered_operation_on;

   // divider only consulted by the master engine
   logic [6:0] half;
   always_comb begin
      case (clock_divider_sel)
         2'h0: half = `SPM_HALF_DIVIDE_BY_FOUR; // see RULE_11
         2'h1: half = `SPM_HALF_DIVIDE_BY_SIXTEEN;
         2'h2: half = `SPM_HALF_DIVIDE_BY_SIXTYFOUR;
         default: half = `SPM_HALF_DIVIDE_BY_128_SEL;
      endcase
      if (clock_double) begin
         half = half >> 1; // see RULE_10
      end
   end
   wire [6:0] half_m1 = half - 7'd1;

   wire m_on = en && master; // see RULE_07, RULE_13
   wire s_act = en && !master && !ss_f; // see RULE_12
   wire takeover = m_on && !select_line_disable && !ss_f; // see RULE_08, RULE_09
   wire tick = m_on && st == spm_pkg::spm_shift && div_cnt == half_m1;
   wire s_rise = s_act && sck_f && !sck_q;
   wire s_fall = s_act && !sck_f && sck_q;
   // slave leans on the far master for polarity and framing
   wire s_lead = cpol ? s_fall : s_rise; // see RULE_22
   wire s_trail = cpol ? s_rise : s_fall;
   wire lead = master ? (tick && !edge_cnt[0]) : s_lead;
   wire trail = master ? (tick && edge_cnt[0]) : s_trail;
   wire smp = cpha ? trail : lead; // see RULE_01, RULE_17
   wire stp = cpha ? lead : trail; // see RULE_01, RULE_17
   wire rx_bit = master ? miso_f : mosi_f;
   wire done = master ? (tick && edge_cnt == 4'hf) : (s_act && smp && nbits == 3'h7);
   wire go = m_on && !takeover && st == spm_pkg::spm_idle
      && (pending_sh || (buffered_operation_on && tx_full)); // see RULE_15
   wire busy = master ? (st == spm_pkg::spm_shift || pending_sh) : (s_act && nbits != 3'h0);

   spm_pkg::spm_byte_t shifted;
   always_comb begin
      if (bit_order) begin
         shifted = {rx_bit, shreg[7:1]}; // see RULE_06
      end else begin
         shifted = {shreg[6:0], rx_bit};
      end
   end
   wire out_bit = bit_order ? shreg[0] : shreg[7]; // see RULE_06
   // pins take the new bit at the setup edge itself; a second register stage would
   // let the bit move on the sample edge when the half period is one cycle
   wire next_data_out = (go || stp || (!master && ss_f)) ? out_bit : data_out; // see RULE_01
   wire [7:0] done_byte = smp ? shifted : shreg;

   wire norm_ok = wr_data && !buffered_operation_on && !busy && !smp;
   wire buf_ok = wr_data && buffered_operation_on && !tx_full;
   // direct load only while the link is quiet and nothing else waits
   wire direct = buf_ok && wait_for_receive && !busy && !smp && (master || ss_f); // see RULE_16
   wire move_tx = done && buffered_operation_on && tx_full;

   // control registers; a takeover clears the role bit
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         main_control <= `SPM_MAIN_CONTROL_RST;
         buffer_and_mode_control <= `SPM_BUF_MODE_RST;
         irq_enable_reg <= `SPM_IRQ_ENABLE_RST;
      end else begin
         if (wr_main) begin
            main_control <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
         end else if (takeover) begin
            main_control[`SPM_MC_MASTER] <= 1'b0; // see RULE_08
         end
         if (wr && mapped && idx == `SPM_IDX_BUF_MODE) begin
            buffer_and_mode_control <= {pwdata[7:6], 3'h0, pwdata[2:0]};
         end
         if (wr && mapped && idx == `SPM_IDX_IRQ_ENABLE) begin
            irq_enable_reg <= {pwdata[7:4], 3'h0, pwdata[0]};
         end
      end
   end

   // master clock engine
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st <= spm_pkg::spm_idle;
         div_cnt <= 7'h00;
         edge_cnt <= 4'h0;
         sck_out <= 1'b0;
      end else if (!m_on || takeover) begin
         st <= spm_pkg::spm_idle;
         div_cnt <= 7'h00;
         edge_cnt <= 4'h0;
         sck_out <= cpol; // see RULE_18
      end else if (st == spm_pkg::spm_idle) begin
         div_cnt <= 7'h00;
         edge_cnt <= 4'h0;
         sck_out <= cpol; // see RULE_18
         if (go) begin
            st <= spm_pkg::spm_shift;
         end
      end else if (tick) begin
         div_cnt <= 7'h00;
         sck_out <= ~sck_out;
         edge_cnt <= edge_cnt + 4'h1;
         if (edge_cnt == 4'hf) begin
            st <= spm_pkg::spm_idle; // see RULE_23
         end
      end else begin
         div_cnt <= div_cnt + 7'h01;
      end
   end

   // sample counter and slave edge history
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         nbits <= 3'h0;
         sck_q <= 1'b0;
      end else begin
         sck_q <= sck_f;
         if (!en || go || (!master && ss_f) || takeover) begin
            nbits <= 3'h0; // see RULE_21
         end else if (smp) begin
            nbits <= nbits + 3'h1;
         end
      end
   end

   // shift register and outgoing bit
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         shreg <= 8'h00;
         data_out <= 1'b0;
         pending_sh <= 1'b0;
      end else begin
         if (move_tx) begin
            shreg <= txbuf;
            pending_sh <= 1'b1;
         end else if (smp) begin
            shreg <= shifted;
         end else if (norm_ok || direct) begin
            shreg <= pwdata[7:0];
            pending_sh <= 1'b1;
         end
         if (go || (done && !move_tx) || !en) begin
            pending_sh <= 1'b0;
         end
         data_out <= next_data_out; // see RULE_01
      end
   end

   // transmit stage of buffered operation; a full stage drops the write
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         txbuf <= 8'h00;
         tx_full <= 1'b0;
      end else begin
         if (move_tx || go) begin
            tx_full <= 1'b0; // see RULE_15
         end
         if (go && !pending_sh) begin
            // dummy goes out first; the buffer waits for the next byte slot
            tx_full <= tx_full;
         end
         if (buf_ok && !direct) begin
            txbuf <= pwdata[7:0];
            tx_full <= 1'b1; // see RULE_14
         end
         if (!buffered_operation_on) begin
            tx_full <= 1'b0;
         end
      end
   end

   // receive stages: two in buffered operation, one otherwise
   wire pop = buffered_operation_on && (rd_data || (wr_flags && pwdata[`SPM_BF_RXC]));
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rx_buf <= 8'h00;
         rx_hold <= 8'h00;
         rx_valid <= 1'b0;
         hold_valid <= 1'b0;
         ovf_flag <= 1'b0;
      end else begin
         if (pop) begin
            rx_buf <= rx_hold;
            rx_valid <= hold_valid;
            hold_valid <= 1'b0;
         end
         if ((rd_data && buffered_operation_on) || (wr_flags && pwdata[`SPM_BF_OVF])) begin
            ovf_flag <= 1'b0;
         end
         if (done && !buffered_operation_on) begin
            rx_buf <= done_byte;
         end else if (done) begin
            if (!rx_valid || (pop && !hold_valid)) begin
               rx_buf <= done_byte; // see RULE_14
               rx_valid <= 1'b1;
            end else if (!hold_valid || pop) begin
               rx_hold <= done_byte;
               hold_valid <= 1'b1;
            end else begin
               ovf_flag <= 1'b1;
            end
         end
      end
   end

   // event flags; a set in the same cycle as a clear wins
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         if_flag <= 1'b0;
         write_collision_flag_flag <= 1'b0;
         txc_flag <= 1'b0;
         select_trigger_flag_flag <= 1'b0;
         arm_if <= 1'b0;
         arm_write_collision_flag <= 1'b0;
      end else begin
         if (rd_flags) begin
            arm_if <= if_flag;
            arm_write_collision_flag <= write_collision_flag_flag;
         end else if (data_touch) begin
            arm_if <= 1'b0;
            arm_write_collision_flag <= 1'b0;
         end
         if (irq_ack || (data_touch && arm_if)) begin
            if_flag <= 1'b0; // see RULE_20
         end
         if (data_touch && arm_write_collision_flag) begin
            write_collision_flag_flag <= 1'b0;
         end
         if (wr_flags && buffered_operation_on) begin
            if (pwdata[`SPM_BF_TXC]) begin
               txc_flag <= 1'b0;
            end
            if (pwdata[`SPM_BF_SELECT_TRIGGER_FLAG]) begin
               select_trigger_flag_flag <= 1'b0;
            end
         end
         if ((done && !buffered_operation_on) || (takeover && !buffered_operation_on)) begin
            if_flag <= 1'b1; // see RULE_08, RULE_20
         end
         if (wr_data && !buffered_operation_on && !norm_ok) begin
            write_collision_flag_flag <= 1'b1; // see RULE_19
         end
         if (done && buffered_operation_on && !tx_full) begin
            txc_flag <= 1'b1;
         end
         if (takeover && buffered_operation_on) begin
            select_trigger_flag_flag <= 1'b1; // see RULE_08
         end
      end
   end

   wire dre_flag = !tx_full;
   wire [7:0] flags_norm = {if_flag, write_collision_flag_flag, 6'h00};
   wire [7:0] flags_buf = {rx_valid, txc_flag, dre_flag, select_trigger_flag_flag, 3'h0, ovf_flag};

   logic [7:0] rd_val;
   always_comb begin
      if (idx == `SPM_IDX_MAIN_CONTROL) begin
         rd_val = main_control;
      end else if (idx == `SPM_IDX_BUF_MODE) begin
         rd_val = buffer_and_mode_control;
      end else if (idx == `SPM_IDX_IRQ_ENABLE) begin
         rd_val = buffered_operation_on ? irq_enable_reg : {7'h00, irq_enable_reg[0]};
      end else if (idx == `SPM_IDX_IRQ_FLAG) begin
         rd_val = buffered_operation_on ? flags_buf : flags_norm;
      end else begin
         rd_val = rx_buf;
      end
   end

   // apb slave: one wait state, data and error ride with pready
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            prdata <= (mapped && !pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
            pslverr <= !mapped;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // pins, interrupt line and event
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
         sck_event <= 1'b0;
         sck_oe_n <= 1'b1;
         mosi_oe_n <= 1'b1;
         miso_oe_n <= 1'b1;
         mosi_out <= 1'b0;
         miso_out <= 1'b0;
      end else begin
         if (buffered_operation_on) begin
            irq <= |(irq_enable_reg[7:4] & flags_buf[7:4]); // see RULE_04, RULE_05
         end else begin
            irq <= irq_enable_reg[`SPM_IE_LEGACY] && (if_flag || write_collision_flag_flag); // see RULE_04
         end
         // the only event leaving the block; nothing comes in
         sck_event <= m_on && sck_out; // see RULE_02, RULE_03
         sck_oe_n <= !m_on;
         mosi_oe_n <= !m_on;
         miso_oe_n <= !s_act;
         mosi_out <= next_data_out;
         miso_out <= next_data_out;
      end
   end

   a_sck_idle: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_18
      (m_on && st == spm_pkg::spm_idle) |=> (sck_out == $past(cpol)))
      else $error("clock not at idle level between bytes");
   a_takeover_drop: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_08
      (takeover && !wr_main) |=> (!master && (if_flag || select_trigger_flag_flag)))
      else $error("takeover did not drop master role");
   a_ssd_holds: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_09
      (m_on && select_line_disable && !wr_main) |=> master)
      else $error("master lost with select disable set");
   a_write_collision_flag_set: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_19
      (wr_data && !buffered_operation_on && busy) |=> write_collision_flag_flag)
      else $error("busy write did not flag collision");
   a_irq_level: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_05
      (!buffered_operation_on && if_flag && irq_enable_reg[0]) |=> irq)
      else $error("interrupt missing while flag set");
   a_byte_end: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_23
      (tick && edge_cnt == 4'hf && !takeover) |=> (st == spm_pkg::spm_idle && sck_out == cpol))
      else $error("byte did not end at idle level");
   a_divide_by_four_half: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_11
      (tick && !clock_double && clock_divider_sel == 2'h0 && edge_cnt != 4'hf && !takeover && !wr_main)
      |=> !tick ##1 tick)
      else $error("divide by four half period wrong");
   a_x2_half: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_10
      (tick && clock_double && clock_divider_sel == 2'h0 && edge_cnt != 4'hf && !takeover && !wr_main)
      |=> tick)
      else $error("doubled clock half period wrong");
   a_ss_reset: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_21
      (en && !master && ss_f) |=> (nbits == 3'h0))
      else $error("slave bit count not cleared by select");
   a_off_quiet: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_13
      !en |=> (sck_oe_n && miso_oe_n && mosi_oe_n))
      else $error("pins driven while disabled");
   a_msb_first: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_06
      (stp && !bit_order && !move_tx) |=> (data_out == $past(shreg[7])))
      else $error("msb not presented first");
endmodule : spm_top

// *** sim/spm_far_slave.sv ***
// behavioural external slave answering the master clock
`timescale 1ns/1ps
module spm_far_slave (
   input wire logic sck, // clock from master
   input wire logic mosi, // data from master
   input wire logic sel_n, // select, low active
   input wire logic [1:0] mode, // transfer mode
   input wire logic lsb, // lsb first when high
   input wire logic [7:0] tx, // byte returned
   output logic miso, // data to master
   output logic [7:0] rx // byte received
);
   int n;
   logic last = 1'b0;
   // select is held low by the bench for the whole byte
   always @(negedge sel_n) n = -int'(mode[1'b0]);
   always @(sck) begin
      if (!sel_n) begin
         if ((sck != mode[1]) ^ mode[0]) rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
         else n++;
      end
   end
   // a released line shows the inverse of its last bit, never a stale copy
   always @* begin
      if (!sel_n && n >= 0 && n < 8) begin
         miso = tx[lsb ? n : 7 - n];
         last = miso;
      end else miso = ~last;
   end
endmodule : spm_far_slave

// *** sim/tb.sv ***
// self-checking bench: apb traffic and master transfers against a far slave
`timescale 1ns/1ps
`include "spm_regs.svh"
module tb;
   logic mclk, resetn, psel, penable, pwrite, irq_ack, ss_n_in, slverr, c2, rb;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, irq, sck_event, sck_out, sck_oe_n, mosi_out, mosi_oe_n;
   logic miso_out, miso_oe_n, far_miso, far_sel_n, far_lsb, sp;
   logic [1:0] far_mode, d;
   logic [7:0] far_tx, far_rx, r;
   int err_count, n_tests, seed, cyc, edges, first_t, last_t;
   spm_top uut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_ack(irq_ack), .irq(irq), .sck_event(sck_event),
      .sck_in(sck_out), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi_out),
      .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(far_miso),
      .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_n_in(ss_n_in));
   spm_far_slave far (.sck(sck_out), .mosi(mosi_out), .sel_n(far_sel_n), .mode(far_mode),
      .lsb(far_lsb), .tx(far_tx), .miso(far_miso), .rx(far_rx));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (sck_out !== sp) begin
         if (edges == 0) first_t = cyc;
         last_t = cyc;
         edges++;
      end
      sp = sck_out;
   end
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] dv);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, dv};
      @(posedge mclk);
      penable <= 1'b1;
      // no cycle count is assumed; only the watchdog ends a hung access
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      r = prdata[7:0];
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb
   task automatic wr(input logic [9:0] a, input logic [7:0] dv);
      apb(1'b1, {a, 2'b00}, dv);
   endtask : wr
   task automatic rd(input logic [9:0] a);
      apb(1'b0, {a, 2'b00}, 8'h00);
   endtask : rd
   function automatic int half_of(input logic [1:0] dv, input logic c);
      int h;
      h = dv == 2'd0 ? 2 : dv == 2'd1 ? 8 : dv == 2'd2 ? 32 : 64;
      return c ? h / 2 : h;
   endfunction : half_of
   task automatic xfer(input logic [1:0] m, input logic lsb, input logic ie, input logic col);
      logic [7:0] tx, rv;
      int k;
      tx = $random(seed);
      rv = $random(seed);
      wr(`SPM_IDX_MAIN_CONTROL, {1'b0, lsb, 1'b1, c2, 1'b0, d, 1'b1});
      wr(`SPM_IDX_BUF_MODE, {6'h0, m});
      wr(`SPM_IDX_IRQ_ENABLE, {7'h0, ie});
      far_mode <= m;
      far_lsb <= lsb;
      far_tx <= rv;
      @(posedge mclk);
      far_sel_n <= 1'b0;
      @(posedge mclk);
      chk("sck idle", sck_out, m[1]);
      edges = 0;
      wr(`SPM_IDX_DATA, tx);
      if (col) wr(`SPM_IDX_DATA, ~tx);
      k = 0;
      do begin
         rd(`SPM_IDX_IRQ_FLAG);
         k++;
      end while (r[7] !== 1'b1 && k < 600);
      chk("flags", r, {1'b1, col, 6'h0});
      if (ie) chk("irq", irq, 1'b1);
      rd(`SPM_IDX_DATA);
      if (half_of(d, c2) >= 8) chk("rx", r, rv);
      rd(`SPM_IDX_IRQ_FLAG);
      chk("flags clr", r, 8'h00);
      chk("irq clr", irq, 1'b0);
      chk("tx", far_rx, tx);
      chk("edges", edges, 16);
      chk("span", last_t - first_t, 15 * half_of(d, c2));
      chk("sck idle after", sck_out, m[1]);
      far_sel_n <= 1'b1;
      $display("transfer mode %0d div %0d done", m, d);
   endtask : xfer
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   initial begin
      repeat (90000) @(posedge mclk);
      err_count++;
      stop_test;
   end
   initial begin
      seed = 32'h32005fcd;
      {resetn, psel, penable, pwrite, irq_ack, sp} = '0;
      {paddr, pwdata, far_mode, far_lsb, far_tx, d, c2} = '0;
      {ss_n_in, far_sel_n} = 2'b11;
      {err_count, n_tests, cyc, edges} = '0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 4; i++) begin
         rd(i[9:0]);
         chk("reset value", r, 8'h00);
      end
      apb(1'b0, 12'h014, 8'h00);
      chk("unmapped", {slverr, r}, 9'h100);
      wr(`SPM_IDX_IRQ_ENABLE, 8'hf1);
      rd(`SPM_IDX_IRQ_ENABLE);
      chk("irq enable", r, 8'h01);
      // master role but disabled: a data write must not start a clock
      wr(`SPM_IDX_MAIN_CONTROL, 8'h20);
      edges = 0;
      wr(`SPM_IDX_DATA, 8'h33);
      repeat (40) @(posedge mclk);
      chk("off edges", edges, 0);
      chk("off oe", {sck_oe_n, mosi_oe_n, miso_oe_n, sck_event}, 4'b1110);
      wr(`SPM_IDX_BUF_MODE, 8'h80);
      rd(`SPM_IDX_IRQ_FLAG);
      chk("buf flags", r, 8'h20);
      rd(`SPM_IDX_IRQ_ENABLE);
      chk("buf irq enable", r, 8'hf1);
      chk("dre irq", irq, 1'b1);
      $display("disabled test done");
      for (int i = 0; i < 12; i++) begin
         d = $random(seed);
         c2 = $random(seed);
         rb = $random(seed);
         if (i == 0) {d, c2} = 3'b110;
         if (i == 1) {d, c2} = 3'b001;
         xfer(i[1:0], i[2], rb, i[0] ^ i[3]);
      end
      wr(`SPM_IDX_BUF_MODE, 8'h00);
      wr(`SPM_IDX_MAIN_CONTROL, 8'h21);
      ss_n_in <= 1'b0;
      repeat (10) @(posedge mclk);
      rd(`SPM_IDX_MAIN_CONTROL);
      chk("takeover role", r, 8'h01);
      chk("slave oe", {sck_oe_n, mosi_oe_n, miso_oe_n}, 3'b110);
      rd(`SPM_IDX_IRQ_FLAG);
      chk("takeover flag", r, 8'h80);
      irq_ack <= 1'b1;
      @(posedge mclk);
      irq_ack <= 1'b0;
      @(posedge mclk);
      rd(`SPM_IDX_IRQ_FLAG);
      chk("ack clears", r, 8'h00);
      ss_n_in <= 1'b1;
      repeat (10) @(posedge mclk);
      wr(`SPM_IDX_BUF_MODE, 8'h04);
      wr(`SPM_IDX_MAIN_CONTROL, 8'h21);
      ss_n_in <= 1'b0;
      repeat (10) @(posedge mclk);
      rd(`SPM_IDX_MAIN_CONTROL);
      chk("ssd role", r, 8'h21);
      rd(`SPM_IDX_IRQ_FLAG);
      chk("ssd flag", r, 8'h00);
      ss_n_in <= 1'b1;
      $display("takeover test done");
      stop_test;
   end
endmodule : tb
